// ===== rtl/srm_top.sv
`timescale 1ns/1ps
`default_nettype none

module srm_top #(
	parameter int unsigned NUM_CH = srm_pkg::NUM_CH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NUM_CH-1:0] modulator_bit,
	input wire logic [NUM_CH-1:0] positive_input_pin_over,
	input wire logic [NUM_CH-1:0] negative_input_pin_over,
	output logic modulator_clock,
	output logic [2:0] range_threshold_sel,
	output logic internal_reference_enable,
	output logic reference_level_sel,
	output logic input_out_of_range_flag,
	output logic data_ready
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] ratio_sel;
		logic [2:0] mod_div;
		logic [2:0] thresh;
		logic iref;
		logic level;
		logic conv;
		logic [NUM_CH-1:0] pos_st;
		logic [NUM_CH-1:0] neg_st;
		logic flag;
		logic ref_high;
		logic new_data;
		logic [2:0] results;
		logic [2:0] div_cnt;
		logic mod_clk;
		logic [12:0] samp_cnt;
		logic [NUM_CH-1:0] bit_s1;
		logic [NUM_CH-1:0] bit_s2;
		logic [NUM_CH-1:0] pos_s1;
		logic [NUM_CH-1:0] pos_s2;
		logic [NUM_CH-1:0] neg_s1;
		logic [NUM_CH-1:0] neg_s2;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
	} srm_state_t;

	localparam srm_state_t STATE_RST = '{
		ratio_sel: srm_pkg::RATIO_RST,
		mod_div: srm_pkg::MODDIV_RST,
		thresh: srm_pkg::THRESH_RST,
		iref: srm_pkg::IREF_RST,
		level: srm_pkg::LEVEL_RST,
		conv: srm_pkg::CONV_RST,
		default: '0
	};

	srm_state_t q;
	srm_state_t d;
	srm_pkg::srm_osr_t osr;
	logic mod_en;
	logic dec_en;
	logic div_hit;
	logic addr_taken;
	logic [31:0] rd;
	logic [NUM_CH-1:0][srm_pkg::OUT_W-1:0] chan_result;

	srm_dec_if dec_if ();

	// ----------------------------------------------------------------
	// Shared timing
	// ----------------------------------------------------------------
	// The strobes are derived from flops only, so every channel sees the same
	// sample and the same decimation instant.
	always_comb begin
		osr = srm_pkg::srm_osr_lookup(q.ratio_sel);
		// Comparing with >= lets a smaller divider written mid-count take
		// effect at once instead of stalling the clock until the count wraps.
		div_hit = (q.div_cnt >= q.mod_div);
		mod_en = q.conv && div_hit && !q.mod_clk;
		dec_en = mod_en && (q.samp_cnt >= (osr.ratio - 13'h0001));
	end

	assign dec_if.mod_en = mod_en;
	assign dec_if.dec_en = dec_en;
	assign dec_if.clear = !q.conv;
	assign dec_if.mult = osr.mult;
	assign dec_if.shift = osr.shift;

	// ----------------------------------------------------------------
	// Channel filters
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
		srm_sinc3 #(
			.ACC_W(srm_pkg::ACC_W),
			.OUT_W(srm_pkg::OUT_W)
		) u_sinc3 (
			.hclk(hclk),
			.hresetn(hresetn),
			.ctl(dec_if),
			.bit_in(q.bit_s2[ch]),
			.result(chan_result[ch])
		);
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		// Offsets that decode to nothing read as zero.
		rd = 32'h0000_0000;
		case (q.addr)
			srm_pkg::ADDR_CLOCK_CONFIG_TWO: begin
				rd[srm_pkg::RATIO_LSB +: 4] = q.ratio_sel;
				rd[srm_pkg::MODDIV_LSB +: 3] = q.mod_div;
			end
			srm_pkg::ADDR_ANALOG_SYSTEM_CONFIG: begin
				rd[srm_pkg::THRESH_LSB +: 3] = q.thresh;
				rd[srm_pkg::IREF_BIT] = q.iref;
				rd[srm_pkg::LEVEL_BIT] = q.level;
				rd[srm_pkg::CONV_BIT] = q.conv;
			end
			srm_pkg::ADDR_STATUS_ONE: begin
				rd[srm_pkg::FLAG_BIT] = q.flag;
				rd[srm_pkg::NEWDATA_BIT] = q.new_data;
				rd[srm_pkg::SETTLED_BIT] = (q.results == srm_pkg::SETTLE_RESULTS);
				rd[srm_pkg::RESULTS_LSB +: 3] = q.results;
			end
			srm_pkg::ADDR_POS_PIN_STATUS: rd[NUM_CH-1:0] = q.pos_st;
			srm_pkg::ADDR_NEG_PIN_STATUS: rd[NUM_CH-1:0] = q.neg_st;
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (q.addr == (srm_pkg::ADDR_DATA_BASE + 8'(4 * i))) begin
						rd[srm_pkg::OUT_W-1:0] = chan_result[i];
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		addr_taken = hsel && hready && htrans[1];

		// ----------------------------------------------------------------
		// Input synchronisers
		// ----------------------------------------------------------------
		d.bit_s1 = modulator_bit;
		d.bit_s2 = q.bit_s1;
		d.pos_s1 = positive_input_pin_over;
		d.pos_s2 = q.pos_s1;
		d.neg_s1 = negative_input_pin_over;
		d.neg_s2 = q.neg_s1;

		// ----------------------------------------------------------------
		// Modulator clock divider
		// ----------------------------------------------------------------
		if (div_hit) begin
			d.div_cnt = 3'h0;
			d.mod_clk = !q.mod_clk;
		end else begin
			d.div_cnt = q.div_cnt + 3'h1;
		end

		// ----------------------------------------------------------------
		// Decimation and settling counters
		// ----------------------------------------------------------------
		// The results count stops at its end value, so the settled bit stays
		// up for as long as conversions run.
		if (!q.conv) begin
			d.samp_cnt = 13'h0000;
			d.results = 3'h0;
		end else if (mod_en) begin
			d.samp_cnt = dec_en ? 13'h0000 : q.samp_cnt + 13'h0001;
		end
		if (dec_en && (q.results != srm_pkg::SETTLE_RESULTS)) begin
			d.results = q.results + 3'h1;
		end

		// ----------------------------------------------------------------
		// Register writes
		// ----------------------------------------------------------------
		// Bus writes land in the data phase; a hardware set in the same
		// cycle as a clear is kept.
		if (q.wr_pend) begin
			case (q.addr)
				srm_pkg::ADDR_CLOCK_CONFIG_TWO: begin
					d.ratio_sel = hwdata[srm_pkg::RATIO_LSB +: 4];
					d.mod_div = hwdata[srm_pkg::MODDIV_LSB +: 3];
				end
				srm_pkg::ADDR_ANALOG_SYSTEM_CONFIG: begin
					d.thresh = hwdata[srm_pkg::THRESH_LSB +: 3];
					d.iref = hwdata[srm_pkg::IREF_BIT];
					d.level = hwdata[srm_pkg::LEVEL_BIT];
					d.conv = hwdata[srm_pkg::CONV_BIT];
				end
				srm_pkg::ADDR_STATUS_ONE: begin
					if (hwdata[srm_pkg::NEWDATA_BIT]) begin
						d.new_data = 1'b0;
					end
				end
				srm_pkg::ADDR_POS_PIN_STATUS: d.pos_st = q.pos_st & ~hwdata[NUM_CH-1:0];
				srm_pkg::ADDR_NEG_PIN_STATUS: d.neg_st = q.neg_st & ~hwdata[NUM_CH-1:0];
				default: d.new_data = d.new_data;
			endcase
		end

		// ----------------------------------------------------------------
		// Pin status and summary flag
		// ----------------------------------------------------------------
		// A pin still beyond its threshold sets its bit again in the cycle
		// that software clears it, so no event is lost to an early clear.
		d.pos_st = d.pos_st | q.pos_s2;
		d.neg_st = d.neg_st | q.neg_s2;
		d.flag = |{d.pos_st, d.neg_st};
		if (dec_en) begin
			d.new_data = 1'b1;
		end
		// The level bit reaches its output only while the internal reference
		// is chosen.
		d.ref_high = d.iref && d.level;

		// ----------------------------------------------------------------
		// Bus handshake
		// ----------------------------------------------------------------
		// Reads take one wait state so that a write just ahead is visible.
		if (q.rd_pend) begin
			d.rdata = rd;
			d.rd_pend = 1'b0;
			d.wr_pend = 1'b0;
		end else begin
			d.wr_pend = addr_taken && hwrite;
			d.rd_pend = addr_taken && !hwrite;
			if (addr_taken) begin
				d.addr = {haddr[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Transfer size is not checked; only whole-word accesses are supported.
	assign hreadyout = !q.rd_pend;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign modulator_clock = q.mod_clk;
	assign range_threshold_sel = q.thresh;
	assign internal_reference_enable = q.iref;
	assign reference_level_sel = q.ref_high;
	assign input_out_of_range_flag = q.flag;
	assign data_ready = q.new_data;

endmodule : srm_top

`default_nettype wire

// ===== rtl/srm_pkg.sv
package srm_pkg;

	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned ACC_W = 40;
	localparam int unsigned OUT_W = 24;
	localparam logic [5:0] FULL_SCALE_SHIFT = 6'h17;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_CONFIG_TWO = 8'h00;
	localparam logic [7:0] ADDR_ANALOG_SYSTEM_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h08;
	localparam logic [7:0] ADDR_POS_PIN_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_NEG_PIN_STATUS = 8'h10;
	localparam logic [7:0] ADDR_DATA_BASE = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned RATIO_LSB = 0;
	localparam int unsigned MODDIV_LSB = 4;
	localparam int unsigned THRESH_LSB = 0;
	localparam int unsigned IREF_BIT = 3;
	localparam int unsigned LEVEL_BIT = 4;
	localparam int unsigned CONV_BIT = 8;
	localparam int unsigned FLAG_BIT = 0;
	localparam int unsigned NEWDATA_BIT = 1;
	localparam int unsigned SETTLED_BIT = 2;
	localparam int unsigned RESULTS_LSB = 4;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [3:0] RATIO_RST = 4'h0;
	localparam logic [2:0] MODDIV_RST = 3'h0;
	localparam logic [2:0] THRESH_RST = 3'h0;
	localparam logic IREF_RST = 1'b0;
	localparam logic LEVEL_RST = 1'b0;
	localparam logic CONV_RST = 1'b0;
	localparam logic [2:0] SETTLE_RESULTS = 3'h4;

	// ----------------------------------------------------------------
	// Decimation ratio table
	// ----------------------------------------------------------------
	// The gain and the division by the cube of the ratio fold into a small
	// multiplier and one arithmetic shift, so no divider is needed.
	typedef struct packed {
		logic [12:0] ratio;
		logic [6:0] mult;
		logic [5:0] shift;
	} srm_osr_t;

	function automatic srm_osr_t srm_osr_lookup(input logic [3:0] code);
		case (code)
			4'h0: srm_osr_lookup = '{13'h1000, 7'h01, 6'h24};
			4'h1: srm_osr_lookup = '{13'h0800, 7'h01, 6'h21};
			4'h2: srm_osr_lookup = '{13'h0400, 7'h01, 6'h1E};
			4'h3: srm_osr_lookup = '{13'h0320, 7'h43, 6'h23};
			4'h4: srm_osr_lookup = '{13'h0300, 7'h13, 6'h21};
			4'h5: srm_osr_lookup = '{13'h0200, 7'h01, 6'h1B};
			4'h6: srm_osr_lookup = '{13'h0190, 7'h43, 6'h20};
			4'h7: srm_osr_lookup = '{13'h0180, 7'h13, 6'h1E};
			4'h8: srm_osr_lookup = '{13'h0100, 7'h01, 6'h18};
			4'h9: srm_osr_lookup = '{13'h00C8, 7'h43, 6'h1D};
			4'hA: srm_osr_lookup = '{13'h00C0, 7'h13, 6'h1B};
			4'hB: srm_osr_lookup = '{13'h0080, 7'h01, 6'h15};
			4'hC: srm_osr_lookup = '{13'h0060, 7'h13, 6'h18};
			4'hD: srm_osr_lookup = '{13'h0040, 7'h01, 6'h12};
			4'hE: srm_osr_lookup = '{13'h0030, 7'h13, 6'h15};
			default: srm_osr_lookup = '{13'h0020, 7'h01, 6'h0F};
		endcase
	endfunction : srm_osr_lookup

endpackage : srm_pkg

// ===== rtl/srm_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface srm_dec_if;
	logic mod_en;
	logic dec_en;
	logic clear;
	logic [6:0] mult;
	logic [5:0] shift;

	modport ctrl (output mod_en, output dec_en, output clear, output mult, output shift);
	modport filt (input mod_en, input dec_en, input clear, input mult, input shift);
endinterface : srm_dec_if

`default_nettype wire

// ===== rtl/srm_sinc3.sv
`timescale 1ns/1ps
`default_nettype none

module srm_sinc3 #(
	parameter int unsigned ACC_W = srm_pkg::ACC_W,
	parameter int unsigned OUT_W = srm_pkg::OUT_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	srm_dec_if.filt ctl,
	input wire logic bit_in,
	output logic [OUT_W-1:0] result
);

	typedef struct packed {
		logic [ACC_W-1:0] i1;
		logic [ACC_W-1:0] i2;
		logic [ACC_W-1:0] i3;
		logic [ACC_W-1:0] z1;
		logic [ACC_W-1:0] z2;
		logic [ACC_W-1:0] z3;
		logic [OUT_W-1:0] filtered;
		logic [OUT_W-1:0] buffered;
	} srm_filt_state_t;

	localparam logic [ACC_W-1:0] STEP_UP = {{(ACC_W-1){1'b0}}, 1'b1};
	localparam logic [ACC_W-1:0] STEP_DOWN = {ACC_W{1'b1}};
	localparam logic signed [63:0] SAT_MAX = (64'sh1 <<< (OUT_W-1)) - 64'sh1;
	localparam logic signed [63:0] SAT_MIN = -(64'sh1 <<< (OUT_W-1));

	srm_filt_state_t q;
	srm_filt_state_t d;
	logic [ACC_W-1:0] c1;
	logic [ACC_W-1:0] c2;
	logic [ACC_W-1:0] c3;
	logic signed [63:0] prod;

	always_comb begin
		d = q;
		c1 = q.i3 - q.z1;
		c2 = c1 - q.z2;
		c3 = c2 - q.z3;
		// Full scale of the comb output is the cube of the ratio; the shift
		// brings it to a 24-bit word, the multiplier carries the gain.
		prod = $signed({{(64-ACC_W){c3[ACC_W-1]}}, c3}) * $signed({57'h0, ctl.mult});
		if (ctl.shift >= srm_pkg::FULL_SCALE_SHIFT) begin
			prod = prod >>> (ctl.shift - srm_pkg::FULL_SCALE_SHIFT);
		end else begin
			prod = prod <<< (srm_pkg::FULL_SCALE_SHIFT - ctl.shift);
		end
		// A full-scale positive stream lands one code past the top at power-of-two ratios, 16385 past at multiplier 19; clamp it.
		if (prod > SAT_MAX) begin
			prod = SAT_MAX;
		end else if (prod < SAT_MIN) begin
			prod = SAT_MIN;
		end
		if (ctl.clear) begin
			d = '0;
		end else begin
			if (ctl.mod_en) begin
				// The integrators chain within one cycle, so no stage adds a
				// sample of delay and the fourth result after wake-up is settled.
				d.i1 = q.i1 + (bit_in ? STEP_UP : STEP_DOWN);
				d.i2 = q.i2 + d.i1;
				d.i3 = q.i3 + d.i2;
			end
			if (ctl.dec_en) begin
				d.z1 = q.i3;
				d.z2 = c1;
				d.z3 = c2;
				d.filtered = prod[OUT_W-1:0];
				d.buffered = q.filtered;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign result = q.buffered;

endmodule : srm_sinc3

`default_nettype wire

// ===== verification/srm_mod_model.sv
`timescale 1ns/1ps
`default_nettype none

module srm_mod_model (
	input wire logic modulator_clock,
	input wire logic [1:0] mode,
	output logic [srm_pkg::NUM_CH-1:0] modulator_bit
);
	logic [1:0] phase_q = 2'h0;

	// Bits move on the falling edge, so they are stable at the sampling rise.
	always @(negedge modulator_clock) begin
		phase_q <= phase_q + 2'h1;
	end

	always_comb begin
		case (mode)
			2'h0: modulator_bit = '1;
			2'h1: modulator_bit = '0;
			2'h2: modulator_bit = {srm_pkg::NUM_CH{phase_q[0]}};
			default: modulator_bit = {srm_pkg::NUM_CH{phase_q != 2'h3}};
		endcase
	end
endmodule : srm_mod_model

`default_nettype wire

// ===== verification/srm_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module srm_top_asserts #(
	parameter int unsigned NUM_CH = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [NUM_CH-1:0] positive_input_pin_over,
	input wire logic [NUM_CH-1:0] negative_input_pin_over,
	input wire logic modulator_clock,
	input wire logic [2:0] range_threshold_sel,
	input wire logic internal_reference_enable,
	input wire logic reference_level_sel,
	input wire logic input_out_of_range_flag
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic cfg_wr_q;
	logic clk_prev_q;
	logic [3:0] stay_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_wr_q <= 1'b0;
			clk_prev_q <= 1'b0;
			stay_q <= 4'h0;
		end else begin
			cfg_wr_q <= hsel && hready && htrans[1] && hwrite
				&& haddr[7:2] == srm_pkg::ADDR_ANALOG_SYSTEM_CONFIG[7:2];
			clk_prev_q <= modulator_clock;
			stay_q <= (modulator_clock != clk_prev_q) ? 4'h0 : stay_q + 4'h1;
		end
	end

	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
	wait_single_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	pos_flag_a: assert property ((positive_input_pin_over != '0)[*3]
		|=> input_out_of_range_flag) else $error("positive pin flag missing");
	neg_flag_a: assert property ((negative_input_pin_over != '0)[*3]
		|=> input_out_of_range_flag) else $error("negative pin flag missing");
	ref_gate_a: assert property (!internal_reference_enable |-> !reference_level_sel)
		else $error("level active with external reference");
	cfg_apply_a: assert property (cfg_wr_q |=>
		range_threshold_sel == $past(hwdata[2:0])
		&& internal_reference_enable == $past(hwdata[3])
		&& reference_level_sel == ($past(hwdata[3]) && $past(hwdata[4])))
		else $error("config write not applied");
	modulator_clock_run_a: assert property (stay_q <= 4'h7)
		else $error("modulator clock stalled");
endmodule : srm_top_asserts

bind srm_top srm_top_asserts #(.NUM_CH(NUM_CH)) srm_top_asserts_inst (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .positive_input_pin_over,
	.negative_input_pin_over, .modulator_clock, .range_threshold_sel,
	.internal_reference_enable, .reference_level_sel, .input_out_of_range_flag);

`default_nettype wire

// ===== verification/sinc3_decimator_range_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sinc3_decimator_range_monitor_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] positive_input_pin_over = 4'h0;
	logic [3:0] negative_input_pin_over = 4'h0;
	logic [1:0] mode = 2'h3;
	logic hreadyout, hresp, modulator_clock, internal_reference_enable;
	logic reference_level_sel, input_out_of_range_flag, data_ready;
	logic [31:0] hrdata, rd;
	logic [2:0] range_threshold_sel;
	logic [3:0] modulator_bit;
	logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20};
	logic [7:0] t_cfg [7] = '{8'h0F, 8'h0E, 8'h09, 8'h1F, 8'h0F, 8'h0F, 8'h0F};
	logic [1:0] t_mode [7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1};
	logic [31:0] t_per [7] = '{32'h40, 32'h60, 32'h190, 32'h80, 32'h40, 32'h40, 32'h40};
	logic [31:0] t_exp [7] = '{32'h400000, 32'h402000, 32'h3FE56C, 32'h400000, 32'h0,
		32'h7FFFFF, 32'h800000};
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int t0 = 0;

	always #10 hclk = ~hclk;

	srm_top srm_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .modulator_bit,
		.positive_input_pin_over, .negative_input_pin_over, .modulator_clock,
		.range_threshold_sel, .internal_reference_enable, .reference_level_sel,
		.input_out_of_range_flag, .data_ready);

	srm_mod_model srm_mod_model_inst (.modulator_clock, .mode, .modulator_bit);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input logic [31:0] tol = 32'h0);
		logic [31:0] diff;
		diff = got - exp;
		total_checks++;
		if (^got === 1'bx || (diff > tol && -diff > tol)) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	localparam logic ON_BUS = 1'b0;
	localparam logic ON_DATA = 1'b1;

	// Returns at the first rising edge that samples the chosen output high:
	// data_ready for ON_DATA, hreadyout for ON_BUS.
	task automatic wait_hi(input logic pick_data);
		@(posedge hclk);
		while ((pick_data ? data_ready : hreadyout) !== 1'b1) @(posedge hclk);
	endtask : wait_hi

	// Starts just after a rising edge; returns at the edge that ends the data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_hi(ON_BUS);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(ON_BUS);
		rd = hrdata;
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (addrs[i]) rchk(addrs[i], 32'h0);
		chk({30'h0, internal_reference_enable, reference_level_sel}, 32'h0);
		$display("reset values done");

		bus(1'b1, 8'h04, 32'h15);
		@(posedge hclk);
		chk({29'h0, range_threshold_sel}, 32'h5);
		chk({31'h0, reference_level_sel}, 32'h0);
		bus(1'b1, 8'h04, 32'h1E);
		@(posedge hclk);
		chk({30'h0, internal_reference_enable, reference_level_sel}, 32'h3);
		rchk(8'h04, 32'h1E);
		bus(1'b1, 8'h04, 32'h0A);
		@(posedge hclk);
		chk({30'h0, internal_reference_enable, reference_level_sel}, 32'h2);
		$display("reference test done");

		positive_input_pin_over <= 4'h4;
		repeat (4) @(posedge hclk);
		chk({31'h0, input_out_of_range_flag}, 32'h1);
		positive_input_pin_over <= 4'h0;
		negative_input_pin_over <= 4'h2;
		rchk(8'h0C, 32'h4);
		rchk(8'h10, 32'h2);
		negative_input_pin_over <= 4'h0;
		bus(1'b1, 8'h0C, 32'h4);
		rchk(8'h08, 32'h1);
		bus(1'b1, 8'h10, 32'h2);
		rchk(8'h08, 32'h0);
		chk({31'h0, input_out_of_range_flag}, 32'h0);
		$display("range test done");

		bus(1'b1, 8'h00, 32'h0F);
		bus(1'b1, 8'h04, 32'h100);
		for (int i = 0; i < 4; i++) begin
			wait_hi(ON_DATA);
			bus(1'b1, 8'h08, 32'h2);
			rchk(8'h08, ((i + 1) << 4) | ((i == 3) ? 32'h4 : 32'h0));
		end
		rchk(8'h20, 32'h400000);
		$display("settle test done");

		foreach (t_cfg[i]) begin
			mode <= t_mode[i];
			bus(1'b1, 8'h00, {24'h0, t_cfg[i]});
			repeat (5) begin
				wait_hi(ON_DATA);
				bus(1'b1, 8'h08, 32'h2);
			end
			wait_hi(ON_DATA);
			t0 = cyc;
			bus(1'b1, 8'h08, 32'h2);
			wait_hi(ON_DATA);
			chk(32'(cyc - t0), t_per[i]);
			for (int c = 0; c < 4; c++) begin
				bus(1'b0, 8'h20 + 8'(4 * c), 32'h0);
				chk(rd, t_exp[i], (i == 2) ? 32'h2 : 32'h0);
			end
			$display("ratio test %0d done", i);
		end
		wrap_up();
	end
endmodule : sinc3_decimator_range_monitor_tb_top

`default_nettype wire
